// ==== include/gpio_port_consts.vh ====
// register offsets, reset values and field positions of the gpio port block
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------------
`define OFS_LCD_DATA     6'h00
`define OFS_LCD_DIR      6'h04
`define OFS_SEG_DISABLE  6'h08
`define OFS_GEN_DATA     6'h0C
`define OFS_GEN_DIR      6'h10
`define OFS_GEN_PULL     6'h14
`define OFS_MULT_IN      6'h18

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_LATCH        32'h00000000
`define RST_DIR          32'h00000000
`define RST_SEG_DISABLE  32'h00000000
`define RST_PULL         32'h00000000

// ----------------------------------------------------------------------
// field positions and bus encodings
// ----------------------------------------------------------------------
`define MULT_PIN_A_BIT   0
`define MULT_PIN_B_BIT   1
`define ADDR_DECODE_MSB  5
`define HTRANS_NONSEQ    2'h2
`define HTRANS_SEQ       2'h3
`define HSIZE_BYTE       3'h0
`define HSIZE_HALF       3'h1
`define HSIZE_WORD       3'h2
`define HRESP_OKAY       1'h0

`endif

// ==== rtl/pin_slice.v ====
// one port pin: input synchroniser, drive enable, pull-up and readback select
`timescale 1ns/10ps
module pin_slice #(
  parameter USE_SEG = 1
) (
  input  wire core_clk,
  input  wire reset,
  input  wire latchBit,
  input  wire dirBit,
  input  wire segDisableBit,
  input  wire pullBit,
  input  wire periphSel,
  input  wire periphVal,
  input  wire pinIn,
  output reg  pinOut_q,
  output reg  pinOe_q,
  output reg  pullEn_q,
  output wire readVal
);

  reg  syncA_q;
  reg  syncB_q;
  wire driveOn;
  wire pullOn;

  // ----------------------------------------------------------------------
  // pin level synchroniser
  // ----------------------------------------------------------------------
  // two stages, only the second is looked at
  always @(posedge core_clk) begin
    if (reset) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
    end
  end

  // ----------------------------------------------------------------------
  // direction and pull-up
  // ----------------------------------------------------------------------
  // lcd pins need segment disable as well, others drive by direction alone and take the pull bit for the pull-up
  generate
    if (USE_SEG != 0) begin : g_lcd
      assign driveOn = dirBit & segDisableBit;
      assign pullOn  = ~dirBit & segDisableBit;
    end else begin : g_gen
      assign driveOn = dirBit;
      assign pullOn  = pullBit & ~dirBit;
    end
  endgenerate

  // registered pad controls; an input pin keeps oe low unless periphSel is set, and floats unless pullOn is set
  always @(posedge core_clk) begin
    if (reset) begin
      pinOut_q <= 1'b0;
      pinOe_q  <= 1'b0;
      pullEn_q <= 1'b0;
    end else begin
      pinOut_q <= periphSel ? periphVal : latchBit;
      pinOe_q  <= driveOn | periphSel;
      pullEn_q <= pullOn & ~periphSel;
    end
  end

  // ----------------------------------------------------------------------
  // readback select
  // ----------------------------------------------------------------------
  // peripheral value first, then latch for outputs, else sensed pin
  assign readVal = periphSel ? periphVal :
                   driveOn   ? latchBit  :
                               syncB_q;

endmodule // pin_slice

// ==== rtl/gpio_direction_port_logic.v ====
// gpio port block: register file on ahb-lite and per-pin port logic
`timescale 1ns/10ps
`include "gpio_port_consts.vh"
module gpio_direction_port_logic #(
  parameter LCD_PINS = 32,
  parameter GEN_PINS = 27
) (
  input  wire                core_clk,
  input  wire                reset,
  // ahb-lite slave
  input  wire                hsel,
  input  wire [31:0]         haddr,
  input  wire [1:0]          htrans,
  input  wire                hwrite,
  input  wire [2:0]          hsize,
  input  wire [31:0]         hwdata,
  input  wire                hready,
  output reg  [31:0]         hrdata,
  output reg                 hreadyout,
  output reg                 hresp,
  // lcd-shared port group pads
  input  wire [LCD_PINS-1:0] lcdPinIn,
  output wire [LCD_PINS-1:0] lcdPinOut,
  output wire [LCD_PINS-1:0] lcdPinOe,
  output wire [LCD_PINS-1:0] lcdPullEn,
  // general port group and last port upper pins pads
  input  wire [GEN_PINS-1:0] genPinIn,
  output wire [GEN_PINS-1:0] genPinOut,
  output wire [GEN_PINS-1:0] genPinOe,
  output wire [GEN_PINS-1:0] genPullEn,
  // peripheral output functions on general pins
  input  wire [GEN_PINS-1:0] periphSel,
  input  wire [GEN_PINS-1:0] periphVal,
  // input-only pins shared with the voltage multiplier
  input  wire                multiplierInputPinA,
  input  wire                multiplierInputPinB,
  input  wire                multiplierOn
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  reg  [LCD_PINS-1:0] lcdLatch_q;
  reg  [LCD_PINS-1:0] lcdDir_q;
  reg  [LCD_PINS-1:0] segDisable_q;
  reg  [GEN_PINS-1:0] genLatch_q;
  reg  [GEN_PINS-1:0] genDir_q;
  reg  [GEN_PINS-1:0] genPull_q;

  // data phase bookkeeping
  reg                 wrPend_q;
  reg  [5:0]          wrAddr_q;
  reg  [31:0]         wrMask_q;

  // multiplier pin synchronisers
  reg                 multSyncA1_q;
  reg                 multSyncA2_q;
  reg                 multSyncB1_q;
  reg                 multSyncB2_q;

  wire [LCD_PINS-1:0] lcdRead;
  wire [GEN_PINS-1:0] genRead;
  wire [1:0]          multRead;

  // ----------------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------------
  wire                addrValid;
  wire [5:0]          addrOfs;
  reg  [31:0]         laneMask;
  reg  [31:0]         rdWord;

  // a transfer is taken only when selected, active and bus ready
  assign addrValid = hsel & hready & htrans[1];
  assign addrOfs   = haddr[`ADDR_DECODE_MSB:0];

  // byte lanes from size and low address bits
  always @* begin
    laneMask = 32'h00000000;
    case (hsize)
      `HSIZE_BYTE: begin
        case (haddr[1:0])
          2'h0:    laneMask = 32'h000000FF;
          2'h1:    laneMask = 32'h0000FF00;
          2'h2:    laneMask = 32'h00FF0000;
          default: laneMask = 32'hFF000000;
        endcase
      end
      `HSIZE_HALF: begin
        laneMask = haddr[1] ? 32'hFFFF0000 : 32'h0000FFFF;
      end
      default: begin
        laneMask = 32'hFFFFFFFF;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // data offsets return per-pin readback, not the raw latch
  always @* begin
    rdWord = 32'h00000000;
    case ({addrOfs[5:2], 2'h0})
      `OFS_LCD_DATA: begin
        rdWord[LCD_PINS-1:0] = lcdRead;
      end
      `OFS_LCD_DIR: begin
        rdWord[LCD_PINS-1:0] = lcdDir_q;
      end
      `OFS_SEG_DISABLE: begin
        rdWord[LCD_PINS-1:0] = segDisable_q;
      end
      `OFS_GEN_DATA: begin
        rdWord[GEN_PINS-1:0] = genRead;
      end
      `OFS_GEN_DIR: begin
        rdWord[GEN_PINS-1:0] = genDir_q;
      end
      `OFS_GEN_PULL: begin
        rdWord[GEN_PINS-1:0] = genPull_q;
      end
      `OFS_MULT_IN: begin
        rdWord[1:0] = multRead;
      end
      default: begin
        rdWord = 32'h00000000;           // unmapped reads as zero
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // bus response
  // ----------------------------------------------------------------------
  // zero wait states; read data is loaded at the address phase edge
  // so it stands through the whole data phase
  always @(posedge core_clk) begin
    if (reset) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
      if (addrValid & ~hwrite) begin
        hrdata <= rdWord;
      end
    end
  end

  // write address held until hwdata arrives in the data phase
  always @(posedge core_clk) begin
    if (reset) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 6'h00;
      wrMask_q <= 32'h00000000;
    end else begin
      if (hready) begin
        wrPend_q <= addrValid & hwrite;
        if (addrValid & hwrite) begin
          wrAddr_q <= addrOfs;
          wrMask_q <= laneMask;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  wire [31:0] wrData;
  wire        wrEn;

  assign wrEn   = wrPend_q;
  assign wrData = hwdata & wrMask_q;

  // merge helper: only enabled byte lanes change
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [31:0] mask;
    begin
      merge = (old & ~mask) | (data & mask);
    end
  endfunction

  // lcd-shared group registers
  always @(posedge core_clk) begin
    if (reset) begin
      lcdLatch_q   <= `RST_LATCH;
      lcdDir_q     <= `RST_DIR;
      segDisable_q <= `RST_SEG_DISABLE;
    end else if (wrEn) begin
      case ({wrAddr_q[5:2], 2'h0})
        `OFS_LCD_DATA: begin
          // writes reach the latch even when the pin is an input
          lcdLatch_q <= merge(lcdLatch_q, wrData, wrMask_q);
        end
        `OFS_LCD_DIR: begin
          lcdDir_q <= merge(lcdDir_q, wrData, wrMask_q);
        end
        `OFS_SEG_DISABLE: begin
          segDisable_q <= merge(segDisable_q, wrData, wrMask_q);
        end
        default: begin
          lcdLatch_q <= lcdLatch_q;
        end
      endcase
    end
  end

  // merged and reset words, cut back to the group width on purpose
  wire [31:0] genLatchMerged = merge({{(32-GEN_PINS){1'b0}}, genLatch_q}, wrData, wrMask_q);
  wire [31:0] genDirMerged   = merge({{(32-GEN_PINS){1'b0}}, genDir_q}, wrData, wrMask_q);
  wire [31:0] genPullMerged  = merge({{(32-GEN_PINS){1'b0}}, genPull_q}, wrData, wrMask_q);
  wire [31:0] genLatchRst    = `RST_LATCH;
  wire [31:0] genDirRst      = `RST_DIR;
  wire [31:0] genPullRst     = `RST_PULL;

  // general group registers; bits above the group width are dropped
  always @(posedge core_clk) begin
    if (reset) begin
      genLatch_q <= genLatchRst[GEN_PINS-1:0];
      genDir_q   <= genDirRst[GEN_PINS-1:0];
      genPull_q  <= genPullRst[GEN_PINS-1:0];
    end else if (wrEn) begin
      case ({wrAddr_q[5:2], 2'h0})
        `OFS_GEN_DATA: begin
          genLatch_q <= genLatchMerged[GEN_PINS-1:0];
        end
        `OFS_GEN_DIR: begin
          genDir_q <= genDirMerged[GEN_PINS-1:0];
        end
        `OFS_GEN_PULL: begin
          genPull_q <= genPullMerged[GEN_PINS-1:0];
        end
        default: begin
          genLatch_q <= genLatch_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // per-pin port logic
  // ----------------------------------------------------------------------
  genvar i;

  // lcd-shared group: no peripheral outputs, pull bits unused
  generate
    for (i = 0; i < LCD_PINS; i = i + 1) begin : g_lcdPin
      pin_slice #(
        .USE_SEG (1)
      ) u_pin (
        .core_clk      (core_clk),
        .reset         (reset),
        .latchBit      (lcdLatch_q[i]),
        .dirBit        (lcdDir_q[i]),
        .segDisableBit (segDisable_q[i]),
        .pullBit       (1'b0),
        .periphSel     (1'b0),
        .periphVal     (1'b0),
        .pinIn         (lcdPinIn[i]),
        .pinOut_q      (lcdPinOut[i]),
        .pinOe_q       (lcdPinOe[i]),
        .pullEn_q      (lcdPullEn[i]),
        .readVal       (lcdRead[i])
      );
    end
  endgenerate

  // general group and last port upper pins
  generate
    for (i = 0; i < GEN_PINS; i = i + 1) begin : g_genPin
      pin_slice #(
        .USE_SEG (0)
      ) u_pin (
        .core_clk      (core_clk),
        .reset         (reset),
        .latchBit      (genLatch_q[i]),
        .dirBit        (genDir_q[i]),
        .segDisableBit (1'b1),
        .pullBit       (genPull_q[i]),
        .periphSel     (periphSel[i]),
        .periphVal     (periphVal[i]),
        .pinIn         (genPinIn[i]),
        .pinOut_q      (genPinOut[i]),
        .pinOe_q       (genPinOe[i]),
        .pullEn_q      (genPullEn[i]),
        .readVal       (genRead[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // multiplier-shared input-only pins
  // ----------------------------------------------------------------------
  // no drive path exists at all, so they can never be outputs
  always @(posedge core_clk) begin
    if (reset) begin
      multSyncA1_q <= 1'b0;
      multSyncA2_q <= 1'b0;
      multSyncB1_q <= 1'b0;
      multSyncB2_q <= 1'b0;
    end else begin
      multSyncA1_q <= multiplierInputPinA;
      multSyncA2_q <= multSyncA1_q;
      multSyncB1_q <= multiplierInputPinB;
      multSyncB2_q <= multSyncB1_q;
    end
  end

  // pin levels are meaningless while the multiplier uses them
  assign multRead[`MULT_PIN_A_BIT] = multiplierOn | multSyncA2_q;
  assign multRead[`MULT_PIN_B_BIT] = multiplierOn | multSyncB2_q;

endmodule // gpio_direction_port_logic

// ==== rtl/unused_placeholder_none.v ====
// intentionally empty of logic: no further modules
`timescale 1ns/10ps

// ==== test/gpio_pad_model.sv ====
// board side of one pin group: external drivers, pull-ups and floating pads
`timescale 1ns/10ps
module gpio_pad_model #(
  parameter N = 32
) (
  input  logic         core_clk,
  input  logic [N-1:0] pinOut,
  input  logic [N-1:0] pinOe,
  input  logic [N-1:0] pullEn,
  input  logic [N-1:0] extVal,
  input  logic [N-1:0] extEn,
  output logic [N-1:0] pinIn
);
  logic [N-1:0] floatQ = '0;
  // an undriven pad wanders each cycle so a stale level is never mistaken for data
  always @(posedge core_clk) floatQ <= ~pinIn;
  // device drive wins, then the board, then the pull-up, else floating
  always_comb
    for (int i = 0; i < N; i++)
      pinIn[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] : pullEn[i] ? 1'b1 : floatQ[i];
endmodule // gpio_pad_model

// ==== test/gpio_direction_port_logic_properties.sv ====
// checker for the gpio port block: bus answer, drive, pull and readback relations
`timescale 1ns/10ps
module gpio_direction_port_logic_properties #(
  parameter LCD_PINS = 32,
  parameter GEN_PINS = 27
) (
  input wire                core_clk,
  input wire                reset,
  input wire                hsel,
  input wire [31:0]         haddr,
  input wire [1:0]          htrans,
  input wire                hwrite,
  input wire                hready,
  input wire [31:0]         hrdata,
  input wire                hreadyout,
  input wire                hresp,
  input wire [LCD_PINS-1:0] lcdPinOe,
  input wire [LCD_PINS-1:0] lcdPullEn,
  input wire [GEN_PINS-1:0] genPinOut,
  input wire [GEN_PINS-1:0] genPinOe,
  input wire [GEN_PINS-1:0] genPullEn,
  input wire [GEN_PINS-1:0] periphSel,
  input wire [GEN_PINS-1:0] periphVal,
  input wire                multiplierOn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------------
  sequence multReadTaken;
    hsel && hready && htrans[1] && !hwrite && haddr[5:0] == 6'h18 && multiplierOn;
  endsequence
  // reset low at both of the last two samples; each assertion checks periphSel itself
  sequence selSteady;
    !$past(reset) && !$past(reset, 2);
  endsequence
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  chk_mult_reads_one: assert property (multReadTaken |=> hrdata[1:0] == 2'h3)
    else $error("multiplier pins did not read as one");
  chk_lcd_pull_drive: assert property ((lcdPinOe & lcdPullEn) == '0)
    else $error("lcd pin pulled up while driving");
  chk_periph_owns_pin: assert property (selSteady |->
    ($past(periphSel) & $past(periphSel, 2) & ~genPinOe) == '0)
    else $error("peripheral pin not driven");
  chk_periph_out_value: assert property (selSteady |->
    ((genPinOut ^ $past(periphVal)) & $past(periphSel) & $past(periphSel, 2)
      & ~($past(periphVal) ^ $past(periphVal, 2))) == '0)
    else $error("peripheral pin drives wrong value");
  chk_periph_no_pull: assert property (selSteady |->
    ($past(periphSel) & $past(periphSel, 2) & genPullEn) == '0)
    else $error("peripheral pin pulled up");
  chk_gen_pull_output: assert property ((genPinOe & genPullEn) == '0)
    else $error("general pin pulled up while output");
  chk_reset_floats: assert property ($fell(reset) |-> lcdPinOe == '0 && genPinOe == '0
    && lcdPullEn == '0 && genPullEn == '0)
    else $error("pins not floating after reset");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule // gpio_direction_port_logic_properties
bind gpio_direction_port_logic gpio_direction_port_logic_properties #(
  .LCD_PINS(LCD_PINS), .GEN_PINS(GEN_PINS)) i_chk (.core_clk(core_clk), .reset(reset),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lcdPinOe(lcdPinOe),
  .lcdPullEn(lcdPullEn), .genPinOut(genPinOut), .genPinOe(genPinOe), .genPullEn(genPullEn),
  .periphSel(periphSel), .periphVal(periphVal), .multiplierOn(multiplierOn));

// ==== test/tb_gpio_direction_port_logic.sv ====
// testbench for the gpio port block: bus, pin groups, peripherals, multiplier pins
`timescale 1ns/10ps
module tb_gpio_direction_port_logic;
  logic        core_clk = 0;
  logic        reset = 1;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        multA = 0, multB = 0, multOn = 0;
  logic [1:0]  htrans = '0;
  logic [31:0] haddr = '0, hwdata = '0, lcdExt = '0, lcdExtEn = '0, rdv;
  logic [26:0] genExt = '0, genExtEn = '0, periphSel = '0, periphVal = '0;
  wire         hreadyout, hresp;
  wire  [31:0] hrdata, lcdPinIn, lcdPinOut, lcdPinOe, lcdPullEn;
  wire  [26:0] genPinIn, genPinOut, genPinOe, genPullEn;
  int          bad_count = 0, tests_run = 0;
  // ----------------------------------------------------------------------
  // clock, design and pads
  // ----------------------------------------------------------------------
  initial forever #5 core_clk = ~core_clk;
  gpio_direction_port_logic i_dut (.core_clk(core_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .lcdPinIn(lcdPinIn), .lcdPinOut(lcdPinOut), .lcdPinOe(lcdPinOe), .lcdPullEn(lcdPullEn),
    .genPinIn(genPinIn), .genPinOut(genPinOut), .genPinOe(genPinOe), .genPullEn(genPullEn),
    .periphSel(periphSel), .periphVal(periphVal), .multiplierInputPinA(multA),
    .multiplierInputPinB(multB), .multiplierOn(multOn));
  gpio_pad_model #(.N(32)) i_lcdPads (.core_clk(core_clk), .pinOut(lcdPinOut),
    .pinOe(lcdPinOe), .pullEn(lcdPullEn), .extVal(lcdExt), .extEn(lcdExtEn), .pinIn(lcdPinIn));
  gpio_pad_model #(.N(27)) i_genPads (.core_clk(core_clk), .pinOut(genPinOut),
    .pinOe(genPinOe), .pullEn(genPullEn), .extVal(genExt), .extEn(genExtEn), .pinIn(genPinIn));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task summarize;
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // a stuck bus ends the run instead of hanging it
  task waitReady;
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        summarize;
      end
      @(posedge core_clk);
    end
  endtask
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    hsel <= 1;
    haddr <= {26'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady;
    rdv = hrdata;
  endtask
  task rd(input string name, input logic [5:0] a, input logic [31:0] exp);
    bus(0, a, 32'h0);
    chk(name, exp, rdv);
  endtask
  // pin outputs lag the registers by one edge, pad inputs by two
  task settle;
    repeat (4) @(posedge core_clk);
  endtask
  // board drives each undriven pin opposite its latch so pin and latch reads differ
  task genCheck(input logic [26:0] dir, pull, lat, sel, val);
    bus(1, 6'h0C, {5'h0, lat});
    bus(1, 6'h10, {5'h0, dir});
    bus(1, 6'h14, {5'h0, pull});
    periphSel <= sel;
    periphVal <= val;
    genExt <= ~(dir ^ lat);
    genExtEn <= ~(dir | sel);
    settle;
    chk("genPinOe", {5'h0, dir | sel}, {5'h0, genPinOe});
    chk("genPullEn", {5'h0, pull & ~dir & ~sel}, {5'h0, genPullEn});
    chk("genPinOut", {5'h0, (sel & val) | (~sel & dir & lat)}, {5'h0, genPinOut & genPinOe});
    rd("genData", 6'h0C, {5'h0, (sel & val) | (~sel & ~(dir ^ lat))});
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task testReset;
    chk("lcdPinOe", 32'h0, lcdPinOe);
    chk("genPinOe", 32'h0, {5'h0, genPinOe});
    rd("lcdDir", 6'h04, 32'h0);
    rd("genDir", 6'h10, 32'h0);
  endtask
  task testLcd;
    logic [31:0] dir, seg, lat;
    dir = 32'h0F0F_00FF;
    seg = 32'h00FF_F0F0;
    lat = 32'h3C3C_5A5A;
    bus(1, 6'h00, lat);
    bus(1, 6'h04, dir);
    bus(1, 6'h08, seg);
    lcdExt <= ~(dir ^ lat);
    lcdExtEn <= ~(dir & seg);
    settle;
    chk("lcdPinOe", dir & seg, lcdPinOe);
    chk("lcdPullEn", ~dir & seg, lcdPullEn);
    chk("lcdPinOut", lat & dir & seg, lcdPinOut & lcdPinOe);
    rd("lcdData", 6'h00, ~(dir ^ lat));
    // turn every pin to output: latch bits written while inputs must now appear
    bus(1, 6'h04, 32'hFFFF_FFFF);
    bus(1, 6'h08, 32'hFFFF_FFFF);
    settle;
    chk("lcdLatchOut", lat, lcdPinOut);
  endtask
  task testGen;
    genCheck(27'h40F_0F0F, 27'h7FF_FFFF, 27'h2AA_AAAA, 27'h0, 27'h0);
  endtask
  task testPeriph;
    genCheck(27'h40F_0F0F, 27'h7FF_FFFF, 27'h2AA_AAAA, 27'h000_00F3, 27'h000_00A1);
    periphSel <= '0;
  endtask
  task testMult;
    multA <= 1;
    settle;
    bus(1, 6'h18, 32'hFFFF_FFFF);
    rd("multIn", 6'h18, 32'h1);
    multA <= 0;
    multOn <= 1;
    settle;
    rd("multOnIn", 6'h18, 32'h3);
    rd("unmapped", 6'h1C, 32'h0);
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    testReset;
    testLcd;
    testGen;
    testPeriph;
    testMult;
    summarize;
  end
endmodule // tb_gpio_direction_port_logic
